// ==== tm16_cfg.svh ====
// constants of the 16-bit timer front end: offsets, field positions, reset values
//
// Overview of operation
// [R1] writing one resets the shared prescaler
// [R2] prescaler reset bit self-clears, reads zero
// [R3] clock select picks clock, tap, or pin
// [R4] no clock selected means no counting
// [R5] compares run always, match sets flag
// [R6] four flag bits, each gated by mask
// [R7] edge captures counter, optional noise filter
// [R8] bottom flagged when counter equals zero
// [R9] max flagged when counter all ones
// [R10] mode selects top: fixed, compare a, capture
// [R11] compare a top buffered, no output a
// [R12] one shared high-byte temporary register
// [R13] low write loads full word at once
// [R14] low read latches high byte into temp
// [R15] compare reads bypass the temporary register
// [R16] software orders high/low bytes correctly
// [R17] software blocks interrupts around byte pairs
// [R18] control registers are plain byte registers
// [R19] force strobes in a, mode bit3 in b
// [R20] cpu counter write beats count or clear
// [R21] prescaler reset acts on next edge
`ifndef TM16_CFG_SVH
`define TM16_CFG_SVH

// register offsets on the 4-bit io address
`define TM16_ADDR_SFIO 4'h0
`define TM16_ADDR_CTL_A 4'h1
`define TM16_ADDR_CTL_B 4'h2
`define TM16_ADDR_CNT_L 4'h3
`define TM16_ADDR_CNT_H 4'h4
`define TM16_ADDR_OCA_L 4'h5
`define TM16_ADDR_OCA_H 4'h6
`define TM16_ADDR_OCB_L 4'h7
`define TM16_ADDR_OCB_H 4'h8
`define TM16_ADDR_CAP_L 4'h9
`define TM16_ADDR_CAP_H 4'ha
`define TM16_ADDR_FLAG 4'hb
`define TM16_ADDR_MASK 4'hc

// field positions
`define TM16_SFIO_PSR 0
`define TM16_CA_FOCA 3
`define TM16_CA_FOCB 2
`define TM16_CB_NOISE 7
`define TM16_CB_EDGE 6
`define TM16_FLAG_LSB 2
// control a keeps com a (7:6), com b (5:4), mode bits 1:0
`define TM16_CA_KEEP 8'hf3
// control b keeps noise, edge, mode bits 3:2 (4:3), clock select (2:0)
`define TM16_CB_KEEP 8'hdf

// reset values
`define TM16_RST_BYTE 8'h00
`define TM16_RST_WORD 16'h0000

// counter landmarks
`define TM16_BOTTOM 16'h0000
`define TM16_MAX 16'hffff
`define TM16_TOP_8 16'h00ff
`define TM16_TOP_9 16'h01ff
`define TM16_TOP_10 16'h03ff

// prescaler
`define TM16_PRE_W 10
`define TM16_PRE_RST 10'h000
`define TM16_NOISE_N 4

`endif

// ==== tm16_clksel.sv ====
// clock select: direct, prescaler tap or synchronised pin edge
`timescale 1ns/1ps
`include "tm16_cfg.svh"
module tm16_clksel import tm16_pkg::*; (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// clock path
	tm16_tclk_if.sel bus
);
	logic s1_r, s2_r, prev_r;
	logic s1_nxt, s2_nxt, prev_nxt;

	always_comb begin
		s1_nxt = bus.ext_pin;
		s2_nxt = s1_r;
		prev_nxt = s2_r;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			prev_r <= prev_nxt;
		end
	end

	always_comb begin
		case (bus.cs) // [R3]
			3'h0: bus.tick = 1'b0; // [R4]
			3'h1: bus.tick = 1'b1;
			3'h2: bus.tick = bus.taps[0];
			3'h3: bus.tick = bus.taps[1];
			3'h4: bus.tick = bus.taps[2];
			3'h5: bus.tick = bus.taps[3];
			3'h6: bus.tick = prev_r & ~s2_r;
			3'h7: bus.tick = ~prev_r & s2_r;
			default: bus.tick = 1'b0;
		endcase
	end
endmodule

// ==== tm16_cpu_model.sv ====
// cpu side of the byte bus: byte transfers and ordered 16-bit pairs
`timescale 1ns/1ps
module tm16_cpu_model (
	// clock
	input wire logic clk_in,
	// byte bus
	output logic [3:0] io_addr_out,
	output logic io_rd_out,
	output logic io_wr_out,
	output logic [7:0] io_wdata_out,
	input wire logic [7:0] io_rdata_in
);
	logic [7:0] dump;
	initial begin
		io_addr_out = 4'h0;
		io_rd_out = 1'b0;
		io_wr_out = 1'b0;
		io_wdata_out = 8'h00;
	end
	// one caller thread only, so no pair is ever split by another temp user
	task automatic xfer(input logic r, input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		io_rd_out = r;
		io_wr_out = w;
		io_addr_out = a;
		io_wdata_out = w ? d : ~io_wdata_out;
		@(negedge clk_in);
		q = io_rdata_in;
	endtask
	task automatic idle();
		xfer(1'b0, 1'b0, 4'h0, 8'h00, dump);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		xfer(1'b0, 1'b1, a, d, dump);
		idle();
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		xfer(1'b1, 1'b0, a, 8'h00, q);
		idle();
	endtask
	task automatic rd2(input logic [3:0] a, output logic [7:0] q);
		xfer(1'b1, 1'b0, a, 8'h00, q);
		rd(a, q);
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		xfer(1'b0, 1'b1, 4'(a + 4'h1), v[15:8], dump);
		wr(a, v[7:0]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		xfer(1'b1, 1'b0, a, 8'h00, v[7:0]);
		rd(4'(a + 4'h1), v[15:8]);
	endtask
endmodule

// ==== tm16_pkg.sv ====
// types of the 16-bit timer front end
package tm16_pkg;
	typedef logic [7:0] tm16_byte_t;
	typedef logic [15:0] tm16_word_t;
	typedef enum logic [5:0] {
		TM16_TOP_MAX = 6'h01,
		TM16_TOP_FF = 6'h02,
		TM16_TOP_1FF = 6'h04,
		TM16_TOP_3FF = 6'h08,
		TM16_TOP_OCA = 6'h10,
		TM16_TOP_CAP = 6'h20
	} tm16_top_t;
endpackage

// ==== tm16_prescaler.sv ====
// free-running shared prescaler with /8 /64 /256 /1024 taps
`timescale 1ns/1ps
`include "tm16_cfg.svh"
module tm16_prescaler import tm16_pkg::*; (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// clock path
	tm16_tclk_if.pre bus
);
	logic [`TM16_PRE_W-1:0] cnt_r;
	logic [`TM16_PRE_W-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = bus.psr ? `TM16_PRE_RST : cnt_r + 10'h001; // [R1] [R21]
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_r <= `TM16_PRE_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// tap pulses when the low bits roll over
	assign bus.taps[0] = &cnt_r[2:0];
	assign bus.taps[1] = &cnt_r[5:0];
	assign bus.taps[2] = &cnt_r[7:0];
	assign bus.taps[3] = &cnt_r[9:0];
endmodule

// ==== tm16_tclk_if.sv ====
// timer clock path between the timer core, the prescaler and clock select
`timescale 1ns/1ps
interface tm16_tclk_if;
	logic psr;
	logic [3:0] taps;
	logic [2:0] cs;
	logic ext_pin;
	logic tick;
	modport pre (input psr, output taps);
	modport sel (input taps, input cs, input ext_pin, output tick);
	modport core (output psr, output cs, output ext_pin, input tick);
endinterface

// ==== tm16_timer16.sv ====
// 16-bit timer core: byte register file, counter, compare, capture and flags
`timescale 1ns/1ps
`include "tm16_cfg.svh"
module tm16_timer16 import tm16_pkg::*; (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// cpu io bus
	input wire logic [3:0] io_addr_in,
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	input wire logic [7:0] io_wdata_in,
	output logic [7:0] io_rdata_out,
	// pins
	input wire logic external_count_pin_in,
	input wire logic capture_pin_in,
	input wire logic comparator_in,
	input wire logic capture_from_comparator_in,
	output logic waveform_out_a_out,
	output logic waveform_out_b_out,
	// interrupt requests
	output logic overflow_irq_out,
	output logic compare_a_irq_out,
	output logic compare_b_irq_out,
	output logic capture_irq_out,
	// status
	output logic bottom_out,
	output logic max_out,
	output logic timer_clock_enable_out
);
	tm16_tclk_if tclk();

	tm16_prescaler u_pre (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.bus(tclk)
	);

	tm16_clksel u_sel (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.bus(tclk)
	);

	////////////////////////////////////////////////////////////////////////////
	// state

	tm16_byte_t ctl_a_r, ctl_a_nxt;
	tm16_byte_t ctl_b_r, ctl_b_nxt;
	tm16_byte_t temp_r, temp_nxt;
	tm16_byte_t rdata_r, rdata_nxt;
	tm16_word_t cnt_r, cnt_nxt;
	tm16_word_t oca_buf_r, oca_buf_nxt;
	tm16_word_t oca_r, oca_nxt;
	tm16_word_t ocb_buf_r, ocb_buf_nxt;
	tm16_word_t ocb_r, ocb_nxt;
	tm16_word_t cap_r, cap_nxt;
	logic [3:0] flag_r, flag_nxt;
	logic [3:0] mask_r, mask_nxt;
	logic [3:0] irq_r, irq_nxt;
	logic [1:0] sync1_r, sync1_nxt;
	logic [1:0] sync2_r, sync2_nxt;
	logic [`TM16_NOISE_N-1:0] hist_r, hist_nxt;
	logic filt_r, filt_nxt;
	logic lvl_prev_r, lvl_prev_nxt;
	logic wave_a_r, wave_a_nxt;
	logic wave_b_r, wave_b_nxt;
	logic bottom_r, bottom_nxt;
	logic max_r, max_nxt;
	logic tick_r, tick_nxt;

	////////////////////////////////////////////////////////////////////////////
	// decode

	logic [3:0] mode;
	logic pwm;
	tm16_top_t top_sel;
	tm16_word_t top_val;
	logic wr_ev, rd_ev;
	logic at_top, at_max;
	logic ovf_ev, match_a, match_b, cap_ev;
	logic lvl, lvl_use;
	logic force_a, force_b;
	logic [3:0] flag_set, flag_clr;

	assign mode = {ctl_b_r[4:3], ctl_a_r[1:0]};
	assign wr_ev = io_wr_in;
	assign rd_ev = io_rd_in;

	// clock path hookups; the reset pulse reaches the prescaler in the write cycle
	assign tclk.psr = wr_ev && (io_addr_in == `TM16_ADDR_SFIO)
		&& io_wdata_in[`TM16_SFIO_PSR]; // [R1] [R21]
	assign tclk.cs = ctl_b_r[2:0]; // [R3]
	assign tclk.ext_pin = external_count_pin_in;

	always_comb begin
		case (mode) // [R10]
			4'h1, 4'h5: top_sel = TM16_TOP_FF;
			4'h2, 4'h6: top_sel = TM16_TOP_1FF;
			4'h3, 4'h7: top_sel = TM16_TOP_3FF;
			4'h4, 4'h9, 4'hb, 4'hf: top_sel = TM16_TOP_OCA;
			4'h8, 4'ha, 4'hc, 4'he: top_sel = TM16_TOP_CAP;
			default: top_sel = TM16_TOP_MAX;
		endcase
	end

	always_comb begin
		case (top_sel) // [R10]
			TM16_TOP_FF: top_val = `TM16_TOP_8;
			TM16_TOP_1FF: top_val = `TM16_TOP_9;
			TM16_TOP_3FF: top_val = `TM16_TOP_10;
			TM16_TOP_OCA: top_val = oca_r;
			TM16_TOP_CAP: top_val = cap_r;
			default: top_val = `TM16_MAX;
		endcase
	end

	// normal, the two clear-on-match modes and mode 13 update compares directly
	assign pwm = !(mode == 4'h0 || mode == 4'h4 || mode == 4'hc || mode == 4'hd);
	assign at_top = (cnt_r == top_val);
	assign at_max = (cnt_r == `TM16_MAX);
	assign ovf_ev = tclk.tick && (pwm ? at_top : at_max); // [R4]
	assign match_a = tclk.tick && (cnt_r == oca_r); // [R5]
	assign match_b = tclk.tick && (cnt_r == ocb_r); // [R5]
	assign force_a = wr_ev && (io_addr_in == `TM16_ADDR_CTL_A)
		&& io_wdata_in[`TM16_CA_FOCA] && !pwm; // [R19]
	assign force_b = wr_ev && (io_addr_in == `TM16_ADDR_CTL_A)
		&& io_wdata_in[`TM16_CA_FOCB] && !pwm; // [R19]

	// capture trigger: pick source after synchronising, then optional filter
	assign lvl = capture_from_comparator_in ? sync2_r[1] : sync2_r[0]; // [R7]
	assign lvl_use = ctl_b_r[`TM16_CB_NOISE] ? filt_r : lvl; // [R7]
	// capture register is the top in those modes, so edges do not overwrite it
	assign cap_ev = (lvl_use != lvl_prev_r) && (lvl_use == ctl_b_r[`TM16_CB_EDGE])
		&& (top_sel != TM16_TOP_CAP); // [R7]

	// compare output action for the com field
	function automatic logic wave_act(input logic cur, input logic [1:0] com);
		case (com)
			2'h1: wave_act = ~cur;
			2'h2: wave_act = 1'b0;
			2'h3: wave_act = 1'b1;
			default: wave_act = cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		ctl_a_nxt = ctl_a_r;
		ctl_b_nxt = ctl_b_r;
		temp_nxt = temp_r;
		rdata_nxt = rdata_r;
		cnt_nxt = cnt_r;
		oca_buf_nxt = oca_buf_r;
		oca_nxt = oca_r;
		ocb_buf_nxt = ocb_buf_r;
		ocb_nxt = ocb_r;
		cap_nxt = cap_r;
		mask_nxt = mask_r;
		flag_clr = 4'h0;
		wave_a_nxt = wave_a_r;
		wave_b_nxt = wave_b_r;

		// counting; wraps at top, a cpu write below overrides it
		if (tclk.tick) begin // [R4]
			cnt_nxt = at_top ? `TM16_BOTTOM : cnt_r + 16'h0001;
		end

		// buffered compares load at top in pwm modes
		if (pwm && tclk.tick && at_top) begin // [R11]
			oca_nxt = oca_buf_r;
			ocb_nxt = ocb_buf_r;
		end

		if (cap_ev) begin
			cap_nxt = cnt_r; // [R7]
		end

		// waveform outputs; channel a is silent when it holds the top in pwm modes
		if ((match_a || force_a) && !(pwm && top_sel == TM16_TOP_OCA)) begin // [R11]
			wave_a_nxt = wave_act(wave_a_r, ctl_a_r[7:6]); // [R5]
		end
		if (match_b || force_b) begin
			wave_b_nxt = wave_act(wave_b_r, ctl_a_r[5:4]); // [R5]
		end

		// cpu writes
		if (wr_ev) begin
			case (io_addr_in)
				`TM16_ADDR_CTL_A: ctl_a_nxt = io_wdata_in & `TM16_CA_KEEP; // [R18] [R19]
				`TM16_ADDR_CTL_B: ctl_b_nxt = io_wdata_in & `TM16_CB_KEEP; // [R18] [R19]
				`TM16_ADDR_CNT_H, `TM16_ADDR_OCA_H, `TM16_ADDR_OCB_H,
				`TM16_ADDR_CAP_H: temp_nxt = io_wdata_in; // [R12]
				`TM16_ADDR_CNT_L: cnt_nxt = {temp_r, io_wdata_in}; // [R13] [R20]
				`TM16_ADDR_OCA_L: begin
					oca_buf_nxt = {temp_r, io_wdata_in}; // [R13]
					if (!pwm) begin
						oca_nxt = {temp_r, io_wdata_in};
					end
				end
				`TM16_ADDR_OCB_L: begin
					ocb_buf_nxt = {temp_r, io_wdata_in}; // [R13]
					if (!pwm) begin
						ocb_nxt = {temp_r, io_wdata_in};
					end
				end
				`TM16_ADDR_CAP_L: begin
					// writable only where it defines the top
					if (top_sel == TM16_TOP_CAP) begin
						cap_nxt = {temp_r, io_wdata_in}; // [R13]
					end
				end
				`TM16_ADDR_FLAG: flag_clr = io_wdata_in[`TM16_FLAG_LSB +: 4]; // [R6]
				`TM16_ADDR_MASK: mask_nxt = io_wdata_in[`TM16_FLAG_LSB +: 4]; // [R6]
				default: ;
			endcase
		end

		// cpu reads, answered from a register one cycle later
		if (rd_ev) begin
			case (io_addr_in)
				`TM16_ADDR_SFIO: rdata_nxt = `TM16_RST_BYTE; // [R2]
				`TM16_ADDR_CTL_A: rdata_nxt = ctl_a_r; // [R18]
				`TM16_ADDR_CTL_B: rdata_nxt = ctl_b_r; // [R18]
				`TM16_ADDR_CNT_L: begin
					rdata_nxt = cnt_r[7:0];
					temp_nxt = cnt_r[15:8]; // [R14]
				end
				`TM16_ADDR_CAP_L: begin
					rdata_nxt = cap_r[7:0];
					temp_nxt = cap_r[15:8]; // [R14]
				end
				`TM16_ADDR_CNT_H, `TM16_ADDR_CAP_H: rdata_nxt = temp_r; // [R14]
				`TM16_ADDR_OCA_L: rdata_nxt = oca_buf_r[7:0]; // [R15]
				`TM16_ADDR_OCA_H: rdata_nxt = oca_buf_r[15:8]; // [R15]
				`TM16_ADDR_OCB_L: rdata_nxt = ocb_buf_r[7:0]; // [R15]
				`TM16_ADDR_OCB_H: rdata_nxt = ocb_buf_r[15:8]; // [R15]
				`TM16_ADDR_FLAG: rdata_nxt = {2'h0, flag_r, 2'h0}; // [R6]
				`TM16_ADDR_MASK: rdata_nxt = {2'h0, mask_r, 2'h0}; // [R6]
				default: rdata_nxt = `TM16_RST_BYTE;
			endcase
		end
	end

	// flags: a new event wins over a clear in the same cycle
	always_comb begin
		flag_set = {cap_ev, match_a, match_b, ovf_ev}; // [R5] [R6] [R7]
		flag_nxt = (flag_r & ~flag_clr) | flag_set; // [R6]
		irq_nxt = flag_nxt & mask_nxt; // [R6]
	end

	// capture synchronisers and noise filter
	always_comb begin
		sync1_nxt = {comparator_in, capture_pin_in};
		sync2_nxt = sync1_r;
		hist_nxt = {hist_r[`TM16_NOISE_N-2:0], lvl};
		filt_nxt = filt_r;
		// filter follows only after a run of equal samples
		if (&hist_r) begin // [R7]
			filt_nxt = 1'b1;
		end else if (~|hist_r) begin
			filt_nxt = 1'b0;
		end
		lvl_prev_nxt = lvl_use;
	end

	// status outputs track the next counter value so they line up with it
	always_comb begin
		bottom_nxt = (cnt_nxt == `TM16_BOTTOM); // [R8]
		max_nxt = (cnt_nxt == `TM16_MAX); // [R9]
		tick_nxt = tclk.tick; // [R3]
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctl_a_r <= `TM16_RST_BYTE;
			ctl_b_r <= `TM16_RST_BYTE;
			temp_r <= `TM16_RST_BYTE;
			rdata_r <= `TM16_RST_BYTE;
			cnt_r <= `TM16_RST_WORD;
			oca_buf_r <= `TM16_RST_WORD;
			oca_r <= `TM16_RST_WORD;
			ocb_buf_r <= `TM16_RST_WORD;
			ocb_r <= `TM16_RST_WORD;
			cap_r <= `TM16_RST_WORD;
			flag_r <= 4'h0;
			mask_r <= 4'h0;
			irq_r <= 4'h0;
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else begin
			ctl_a_r <= ctl_a_nxt;
			ctl_b_r <= ctl_b_nxt;
			temp_r <= temp_nxt;
			rdata_r <= rdata_nxt;
			cnt_r <= cnt_nxt;
			oca_buf_r <= oca_buf_nxt;
			oca_r <= oca_nxt;
			ocb_buf_r <= ocb_buf_nxt;
			ocb_r <= ocb_nxt;
			cap_r <= cap_nxt;
			flag_r <= flag_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
			wave_a_r <= wave_a_nxt;
			wave_b_r <= wave_b_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
			hist_r <= 4'h0;
			filt_r <= 1'b0;
			lvl_prev_r <= 1'b0;
			bottom_r <= 1'b1;
			max_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			hist_r <= hist_nxt;
			filt_r <= filt_nxt;
			lvl_prev_r <= lvl_prev_nxt;
			bottom_r <= bottom_nxt;
			max_r <= max_nxt;
			tick_r <= tick_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign io_rdata_out = rdata_r;
	assign waveform_out_a_out = wave_a_r;
	assign waveform_out_b_out = wave_b_r;
	assign overflow_irq_out = irq_r[0];
	assign compare_b_irq_out = irq_r[1];
	assign compare_a_irq_out = irq_r[2];
	assign capture_irq_out = irq_r[3];
	assign bottom_out = bottom_r;
	assign max_out = max_r;
	assign timer_clock_enable_out = tick_r;
endmodule

// ==== tm16_timer16_checker.sv ====
// assertions on the byte bus and status ports of the timer front end
`timescale 1ns/1ps
`include "tm16_cfg.svh"
module tm16_timer16_checker (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// cpu io bus
	input wire logic [3:0] io_addr_in,
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic [7:0] io_rdata_out,
	// status
	input wire logic bottom_out,
	input wire logic max_out,
	input wire logic timer_clock_enable_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////
	a_psr_reads_zero: assert property (
		io_rd_in && io_addr_in == `TM16_ADDR_SFIO |=> io_rdata_out == 8'h00
	) else $error("prescaler reset bit read back set");
	a_strobe_reads_zero: assert property (
		io_rd_in && io_addr_in == `TM16_ADDR_CTL_A |=> io_rdata_out[3:2] == 2'h0
	) else $error("force strobes read back set");
	a_flag_layout: assert property (
		io_rd_in && io_addr_in == `TM16_ADDR_FLAG |=> (io_rdata_out & 8'hc3) == 8'h00
	) else $error("unused flag bits read back set");
	a_compare_high_stable: assert property (
		(io_rd_in && io_addr_in == `TM16_ADDR_OCA_H) ##1 (io_rd_in && io_addr_in == `TM16_ADDR_OCA_H)
		|=> $stable(io_rdata_out)
	) else $error("compare high byte changed between reads");
	a_temp_high_stable: assert property (
		(io_rd_in && io_addr_in == `TM16_ADDR_CNT_H) ##1 (io_rd_in && io_addr_in == `TM16_ADDR_CNT_H)
		|=> $stable(io_rdata_out)
	) else $error("temporary byte changed by a high read");
	a_bottom_after_write: assert property (
		(io_wr_in && io_addr_in == `TM16_ADDR_CNT_H && io_wdata_in == 8'h00)
		##1 (io_wr_in && io_addr_in == `TM16_ADDR_CNT_L && io_wdata_in == 8'h00) |=> bottom_out
	) else $error("bottom not flagged after zero write");
	a_max_after_write: assert property (
		(io_wr_in && io_addr_in == `TM16_ADDR_CNT_H && io_wdata_in == 8'hff)
		##1 (io_wr_in && io_addr_in == `TM16_ADDR_CNT_L && io_wdata_in == 8'hff) |=> max_out
	) else $error("max not flagged after all-ones write");
	a_bottom_max_excl: assert property (
		!(bottom_out && max_out)
	) else $error("bottom and max flagged together");
	a_stop_no_tick: assert property (
		(io_wr_in && io_addr_in == `TM16_ADDR_CTL_B && io_wdata_in[2:0] == 3'h0)
		##1 !(io_wr_in && io_addr_in == `TM16_ADDR_CTL_B) [*6] |-> !timer_clock_enable_out
	) else $error("timer clock enable while stopped");
endmodule
bind tm16_timer16 tm16_timer16_checker i_tm16_timer16_checker (.clk_in, .rst_n_in, .io_addr_in,
	.io_rd_in, .io_wr_in, .io_wdata_in, .io_rdata_out, .bottom_out, .max_out,
	.timer_clock_enable_out);

// ==== tm16_timer16_tb_top.sv ====
// self-checking bench of the 16-bit timer front end
`timescale 1ns/1ps
`include "tm16_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tm16_timer16_tb_top import tm16_pkg::*;;
	logic clk_in, rst_n_in, ext_pin, cap_pin, cmp, cmp_sel, wave_a, wave_b, bottom, max_hit, tick;
	logic [3:0] io_addr;
	logic io_rd, io_wr;
	logic [7:0] io_wdata, io_rdata;
	logic [3:0] irq;
	logic [3:0] ctl [3];
	int mismatches, checks_done, c;
	tm16_byte_t q;
	tm16_word_t v, w;
	tm16_timer16 i_tm16_timer16 (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr),
		.io_rd_in(io_rd), .io_wr_in(io_wr), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
		.external_count_pin_in(ext_pin), .capture_pin_in(cap_pin), .comparator_in(cmp),
		.capture_from_comparator_in(cmp_sel), .waveform_out_a_out(wave_a),
		.waveform_out_b_out(wave_b), .overflow_irq_out(irq[0]), .compare_b_irq_out(irq[1]),
		.compare_a_irq_out(irq[2]), .capture_irq_out(irq[3]), .bottom_out(bottom),
		.max_out(max_hit), .timer_clock_enable_out(tick));
	tm16_cpu_model i_tm16_cpu_model (.clk_in(clk_in), .io_addr_out(io_addr), .io_rd_out(io_rd),
		.io_wr_out(io_wr), .io_wdata_out(io_wdata), .io_rdata_in(io_rdata));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	////////////////////////////////////////
	function automatic tm16_byte_t keep(input logic [3:0] a, input tm16_byte_t d);
		keep = d & (a == `TM16_ADDR_CTL_A ? `TM16_CA_KEEP : a == `TM16_ADDR_CTL_B ? `TM16_CB_KEEP
			: 8'h3c);
	endfunction
	// prescaled windows span two periods plus pipeline slack
	function automatic int win(input int cs);
		win = cs == 2 ? 19 : cs == 3 ? 131 : cs == 4 ? 515 : cs == 5 ? 2051 : 30;
	endfunction
	function automatic int exp_ticks(input int cs);
		exp_ticks = cs == 0 ? 0 : cs == 1 ? 30 : cs > 5 ? 3 : 2;
	endfunction
	task automatic give_verdict();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic ticks(input int cyc, output int n);
		n = 0;
		for (int i = 1; i <= cyc; i++) begin
			@(negedge clk_in);
			n += int'(tick === 1'b1);
			ext_pin = i[2] && i < 24;
		end
	endtask
	task automatic wait_irq(input int b);
		int n;
		for (n = 0; n < 100 && irq[b] !== 1'b1; n++) begin
			@(negedge clk_in);
		end
		if (n == 100) begin
			mismatches++;
			give_verdict();
		end
	endtask
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h3c49ac88));
		{rst_n_in, ext_pin, cap_pin, cmp, cmp_sel} = 5'h00;
		mismatches = 0;
		checks_done = 0;
		repeat (6) @(negedge clk_in);
		rst_n_in = 1'b1;
		for (int a = 0; a < 16; a++) begin
			i_tm16_cpu_model.rd(4'(a), q);
			`CHK(q, 8'h00)
		end
		ctl = '{`TM16_ADDR_CTL_A, `TM16_ADDR_CTL_B, `TM16_ADDR_MASK};
		repeat (3) foreach (ctl[k]) begin
			v = 16'($urandom);
			i_tm16_cpu_model.wr(ctl[k], v[7:0]);
			i_tm16_cpu_model.rd(ctl[k], q);
			`CHK(q, keep(ctl[k], v[7:0]))
		end
		foreach (ctl[k]) i_tm16_cpu_model.wr(ctl[k], 8'h00);
		v = 16'($urandom);
		i_tm16_cpu_model.wr16(`TM16_ADDR_CNT_L, v);
		i_tm16_cpu_model.rd16(`TM16_ADDR_CNT_L, w);
		`CHK(w, v)
		i_tm16_cpu_model.wr16(`TM16_ADDR_OCA_L, ~v);
		i_tm16_cpu_model.rd(`TM16_ADDR_CNT_L, q);
		i_tm16_cpu_model.rd2(`TM16_ADDR_OCA_H, q);
		`CHK(q, ~v[15:8])
		i_tm16_cpu_model.rd2(`TM16_ADDR_CNT_H, q);
		`CHK(q, v[15:8])
		i_tm16_cpu_model.wr(`TM16_ADDR_CNT_H, 8'h5a);
		i_tm16_cpu_model.rd16(`TM16_ADDR_OCA_L, w);
		`CHK(w, ~v)
		i_tm16_cpu_model.wr(`TM16_ADDR_CNT_L, 8'h11);
		i_tm16_cpu_model.rd16(`TM16_ADDR_CNT_L, w);
		`CHK(w, 16'h5a11)
		i_tm16_cpu_model.wr16(`TM16_ADDR_CNT_L, 16'h0000);
		`CHK({bottom, max_hit}, 2'b10)
		i_tm16_cpu_model.wr16(`TM16_ADDR_CNT_L, 16'hffff);
		`CHK({bottom, max_hit}, 2'b01)
		// force acts with the compare action already held, so set it first
		i_tm16_cpu_model.wr(`TM16_ADDR_CTL_A, 8'hf0);
		i_tm16_cpu_model.wr(`TM16_ADDR_CTL_A, 8'hfc);
		`CHK({wave_a, wave_b}, 2'b11)
		i_tm16_cpu_model.wr(`TM16_ADDR_CTL_A, 8'h50);
		i_tm16_cpu_model.wr(`TM16_ADDR_CTL_A, 8'h5c);
		`CHK({wave_a, wave_b}, 2'b00)
		i_tm16_cpu_model.wr16(`TM16_ADDR_OCB_L, v);
		i_tm16_cpu_model.wr16(`TM16_ADDR_CNT_L, v - 16'h0008);
		i_tm16_cpu_model.wr(`TM16_ADDR_FLAG, 8'hff);
		i_tm16_cpu_model.wr(`TM16_ADDR_MASK, 8'h08);
		i_tm16_cpu_model.wr(`TM16_ADDR_CTL_B, 8'h01);
		wait_irq(1);
		i_tm16_cpu_model.rd(`TM16_ADDR_FLAG, q);
		`CHK(q & 8'h08, 8'h08)
		`CHK(irq, 4'b0010)
		i_tm16_cpu_model.wr16(`TM16_ADDR_CNT_L, 16'hfff0);
		repeat (30) @(negedge clk_in);
		i_tm16_cpu_model.rd(`TM16_ADDR_FLAG, q);
		`CHK(q & 8'h04, 8'h04)
		`CHK(irq[0], 1'b0)
		i_tm16_cpu_model.wr(`TM16_ADDR_CTL_B, 8'h00);
		i_tm16_cpu_model.wr(`TM16_ADDR_FLAG, 8'hff);
		i_tm16_cpu_model.rd(`TM16_ADDR_FLAG, q);
		`CHK(q, 8'h00)
		for (int s = 0; s < 2; s++) begin
			v = 16'($urandom);
			cmp_sel = s[0];
			i_tm16_cpu_model.wr16(`TM16_ADDR_CNT_L, v);
			i_tm16_cpu_model.wr(`TM16_ADDR_CTL_B, 8'h40);
			i_tm16_cpu_model.wr(`TM16_ADDR_FLAG, 8'hff);
			if (s == 0) cap_pin = 1'b1; else cmp = 1'b1;
			repeat (8) @(negedge clk_in);
			i_tm16_cpu_model.rd16(`TM16_ADDR_CAP_L, w);
			`CHK(w, v)
			i_tm16_cpu_model.rd(`TM16_ADDR_FLAG, q);
			`CHK({q & 8'h20, irq[3]}, 9'h040)
		end
		for (int cs = 0; cs < 8; cs++) begin
			i_tm16_cpu_model.wr(`TM16_ADDR_CTL_B, 8'(cs));
			i_tm16_cpu_model.wr(`TM16_ADDR_SFIO, 8'h01);
			ticks(win(cs), c);
			`CHK(c, exp_ticks(cs))
			// the count alone would let an unknown enable pass as zero
			`CHK(tick, cs == 1)
			i_tm16_cpu_model.rd(`TM16_ADDR_SFIO, q);
			`CHK(q, 8'h00)
		end
		give_verdict();
	end
endmodule
